// File: common/qdac_pkg.sv
// Shared constants for the quad converter input front end
package qdac_pkg;
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 2;
  localparam int          WORD_W      = 12;
  localparam int          NUM_CH      = 4;
  localparam int          WORD_DATA_LSB = 0;
  localparam int          WORD_ADDR_LSB = 8;
  localparam int          WORD_SDC_BIT  = 10;
  localparam int          WORD_SAC_BIT  = 11;
  localparam logic [7:0]  ZERO_CODE   = 8'h00;
  localparam logic [11:0] WORD_RESET  = 12'h000;
  localparam logic [1:0]  ADDR_A      = 2'h0;
  localparam logic [1:0]  ADDR_B      = 2'h1;
  localparam logic [1:0]  ADDR_C      = 2'h2;
  localparam logic [1:0]  ADDR_D      = 2'h3;
  localparam int          FULL_SCALE_DIV = 256;
endpackage : qdac_pkg

// File: core/qdac_sync.sv
// Two-flop synchroniser with edge flags on the second stage
`timescale 1ns/1ps
`default_nettype none
module qdac_sync (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic rst_val_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Reset value is a constant at the instance, so it is a literal in effect
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
      prev_q <= rst_val_in;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule : qdac_sync
`default_nettype wire

// File: core/qdac_core.sv
// Quad 8-bit converter digital front end: serial and parallel variants
//
// Behaviour
// R01 - Low load strobe copies all four input registers to DAC registers together.
// R02 - DAC registers stay transparent while load strobe low, latch on rise.
// R03 - Low clear zeroes all input and DAC registers without serial clock.
// R04 - Clear leaves the serial shift register untouched.
// R05 - Chip select high blocks serial clock; no shifting occurs.
// R06 - Chip select rise moves shifted data into the addressed input register.
// R07 - Chip select does not affect load strobe behaviour.
// R08 - Serial data sampled on serial clock rising edge while selected.
// R09 - Serial word arrives MSB first and shifts straight in.
// R10 - Floating serial data or low address pin requests hardware powerdown.
// R11 - Powerdown entry and exit keep DAC register contents.
// R12 - During powerdown every channel output is open circuit.
// R13 - Parallel byte on eight lines, top line is MSB.
// R14 - Parallel data accepted only under the low write strobe.
// R15 - Two address inputs pick one of four registers; low doubles as powerdown.
// R16 - Channel output is reference times code over 256.
// R17 - Serial word is twelve bits, sent within one selection.
// R18 - Extra bits: only the last twelve count at chip select rise.
// R19 - Address codes 00,01,10,11 select registers A,B,C,D.
// R20 - Reset zeroes all input and DAC registers until a load.
// R21 - Held clear overrides any concurrent transfer or load.
`timescale 1ns/1ps
`default_nettype none
module qdac_core (
  input  wire logic       REF_CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic       PARALLEL_MODE_IN,
  input  wire logic       CHIP_SEL_N_IN,
  input  wire logic       SERIAL_CLK_IN,
  input  wire logic       SERIAL_IN_OR_POWERDOWN_IN,
  input  wire logic       SERIAL_IN_FLOAT_IN,
  input  wire logic [7:0] PAR_DATA_IN,
  input  wire logic       WRITE_STROBE_N_IN,
  input  wire logic       REG_SELECT_HI_IN,
  input  wire logic       REG_SELECT_LO_OR_POWERDOWN_IN,
  input  wire logic       REG_SELECT_LO_FLOAT_IN,
  input  wire logic       LOAD_OUTPUT_STROBE_N_IN,
  input  wire logic       ASYNC_ZERO_N_IN,
  output logic [7:0]      CHANNEL_A_OUTPUT_OUT,
  output logic [7:0]      CHANNEL_B_OUTPUT_OUT,
  output logic [7:0]      CHANNEL_C_OUTPUT_OUT,
  output logic [7:0]      CHANNEL_D_OUTPUT_OUT,
  output logic [3:0]      CHANNEL_DRIVE_EN_OUT,
  output logic            HW_POWERDOWN_OUT,
  output logic [3:0]      SW_POWERDOWN_OUT
);
  // Pin inputs through two flops before any logic reads them
  logic cs_lvl;
  logic cs_rise;
  logic sclk_rise;
  logic sdi_lvl;
  logic sdi_flt;
  logic wr_lvl;
  logic wr_rise;
  logic sel_hi;
  logic sel_lo;
  logic sel_lo_flt;
  logic ld_lvl;
  logic zero_lvl;
  logic [7:0] pdat_s;

  qdac_sync u_cs (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b1),
    .async_in(CHIP_SEL_N_IN), .level_out(cs_lvl), .rise_out(cs_rise),
    .fall_out());
  qdac_sync u_sclk (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(SERIAL_CLK_IN), .level_out(), .rise_out(sclk_rise),
    .fall_out());
  qdac_sync u_sdi (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(SERIAL_IN_OR_POWERDOWN_IN), .level_out(sdi_lvl), .rise_out(),
    .fall_out());
  qdac_sync u_sdf (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(SERIAL_IN_FLOAT_IN), .level_out(sdi_flt), .rise_out(),
    .fall_out());
  qdac_sync u_wr (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b1),
    .async_in(WRITE_STROBE_N_IN), .level_out(wr_lvl), .rise_out(wr_rise),
    .fall_out());
  qdac_sync u_ahi (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(REG_SELECT_HI_IN), .level_out(sel_hi), .rise_out(),
    .fall_out());
  qdac_sync u_alo (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(REG_SELECT_LO_OR_POWERDOWN_IN), .level_out(sel_lo),
    .rise_out(), .fall_out());
  qdac_sync u_alf (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b0),
    .async_in(REG_SELECT_LO_FLOAT_IN), .level_out(sel_lo_flt), .rise_out(),
    .fall_out());
  qdac_sync u_ld (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b1),
    .async_in(LOAD_OUTPUT_STROBE_N_IN), .level_out(ld_lvl), .rise_out(),
    .fall_out());
  qdac_sync u_clr (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .rst_val_in(1'b1),
    .async_in(ASYNC_ZERO_N_IN), .level_out(zero_lvl), .rise_out(),
    .fall_out());

  genvar gi;
  generate
    for (gi = 0; gi < qdac_pkg::DATA_W; gi++) begin : g_pd
      qdac_sync u_pd (.clk_in(REF_CLK_IN), .srst_in(SRST_IN),
        .rst_val_in(1'b0), .async_in(PAR_DATA_IN[gi]),
        .level_out(pdat_s[gi]), .rise_out(), .fall_out());
    end
  endgenerate

  // Mode strap is held steady by the board; same treatment anyway
  logic par_mode;
  qdac_sync u_mode (.clk_in(REF_CLK_IN), .srst_in(SRST_IN),
    .rst_val_in(1'b0), .async_in(PARALLEL_MODE_IN), .level_out(par_mode),
    .rise_out(), .fall_out());

  // Decode helper used by both variants
  function automatic logic [3:0] qdac_onehot(input logic [1:0] a);
    logic [3:0] r;
    r = 4'h0;
    unique case (a)
      qdac_pkg::ADDR_A: r = 4'h1;
      qdac_pkg::ADDR_B: r = 4'h2;
      qdac_pkg::ADDR_C: r = 4'h4;
      qdac_pkg::ADDR_D: r = 4'h8;
    endcase
    return r;
  endfunction : qdac_onehot

  logic [11:0] shift_q;
  logic [11:0] shift_d;
  logic [7:0]  in_q  [4];
  logic [7:0]  dac_q [4];
  logic [3:0]  sw_pd_q;
  logic        hw_pd_q;
  logic [7:0]  out_q [4];
  logic [3:0]  drv_q;

  wire         zero_act  = ~zero_lvl;
  wire         load_act  = ~ld_lvl;
  wire         shift_en  = ~par_mode & ~cs_lvl & sclk_rise; // R05 R08
  wire [1:0]   word_addr = shift_q[qdac_pkg::WORD_ADDR_LSB +: 2];
  wire [7:0]   word_data = shift_q[qdac_pkg::WORD_DATA_LSB +: 8];
  wire [3:0]   ser_sel   = qdac_onehot(word_addr); // R19
  wire         ser_xfer  = ~par_mode & cs_rise; // R06 R18
  wire [1:0]   par_addr  = {sel_hi, sel_lo}; // R15
  wire [3:0]   par_sel   = qdac_onehot(par_addr); // R19
  // Write low is a transparent latch; rise keeps the last value
  wire         par_wr    = par_mode & ~wr_lvl; // R14
  wire         hw_pd_req = par_mode ? sel_lo_flt : sdi_flt; // R10

  // Shift word MSB first; clear does not touch it, so no zero term
  assign shift_d = {shift_q[10:0], sdi_lvl}; // R09 R04 R17

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      shift_q <= qdac_pkg::WORD_RESET;
    end else if (shift_en) begin
      shift_q <= shift_d;
    end
  end

  // Input registers; clear beats transfer and write
  always_ff @(posedge REF_CLK_IN) begin
    for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
      if (SRST_IN || zero_act) begin // R20 R03 R21
        in_q[i] <= qdac_pkg::ZERO_CODE;
      end else if (ser_xfer && ser_sel[i]) begin // R06
        in_q[i] <= word_data;
      end else if (par_wr && par_sel[i]) begin // R13 R14
        in_q[i] <= pdat_s;
      end
    end
  end

  // DAC registers follow input registers while load is low, ignoring select
  always_ff @(posedge REF_CLK_IN) begin
    for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
      if (SRST_IN || zero_act) begin // R20 R03 R21
        dac_q[i] <= qdac_pkg::ZERO_CODE;
      end else if (load_act) begin // R01 R02 R07
        dac_q[i] <= in_q[i];
      end
    end
  end

  // Software powerdown bits from the serial word, active low in the word
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      sw_pd_q <= 4'h0;
    end else if (ser_xfer) begin
      if (!shift_q[qdac_pkg::WORD_SAC_BIT]) begin
        sw_pd_q <= 4'hf;
      end else if (!shift_q[qdac_pkg::WORD_SDC_BIT]) begin
        sw_pd_q <= ser_sel;
      end else begin
        sw_pd_q <= 4'h0;
      end
    end
  end

  // Powerdown only gates the outputs; DAC codes stay intact
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      hw_pd_q <= 1'b0;
      drv_q   <= 4'h0;
      for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
        out_q[i] <= qdac_pkg::ZERO_CODE;
      end
    end else begin
      hw_pd_q <= hw_pd_req; // R10 R11
      for (int i = 0; i < qdac_pkg::NUM_CH; i++) begin
        // Code is the fraction of full scale: Vout = Vref*code/256
        out_q[i] <= dac_q[i]; // R16
        drv_q[i] <= ~(hw_pd_req | sw_pd_q[i]); // R12
      end
    end
  end

  assign CHANNEL_A_OUTPUT_OUT = out_q[0];
  assign CHANNEL_B_OUTPUT_OUT = out_q[1];
  assign CHANNEL_C_OUTPUT_OUT = out_q[2];
  assign CHANNEL_D_OUTPUT_OUT = out_q[3];
  assign CHANNEL_DRIVE_EN_OUT = drv_q;
  assign HW_POWERDOWN_OUT     = hw_pd_q;
  assign SW_POWERDOWN_OUT     = sw_pd_q;

  // Assertions
  sequence s_clear_held;
    zero_act [*2];
  endsequence
  // Load seen at one edge reaches the output register two edges later
  sequence s_load_open;
    load_act && !zero_act;
  endsequence
  sequence s_par_write_d;
    par_wr && !zero_act && par_addr == 2'h3;
  endsequence

  AST_LOAD_COPIES: assert property ( // R01
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (load_act && !zero_act) |=> (dac_q[0] == $past(in_q[0])
      && dac_q[3] == $past(in_q[3])))
    else $error("DAC register missed load");
  AST_LATCH_HOLD: assert property ( // R02
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (!load_act && !zero_act) |=> $stable(dac_q[1]))
    else $error("DAC register moved without load");
  AST_CLEAR_ZERO: assert property ( // R03
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    zero_act |=> (in_q[2] == 8'h00 && dac_q[2] == 8'h00))
    else $error("Clear did not zero registers");
  AST_CLEAR_KEEPS_SHIFT: assert property ( // R04
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (zero_act && shift_en) |=> shift_q == $past(shift_d))
    else $error("Clear disturbed shift register");
  AST_NO_SHIFT_DESEL: assert property ( // R05
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    cs_lvl |=> $stable(shift_q))
    else $error("Shift while deselected");
  AST_XFER_ADDR: assert property ( // R06
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (ser_xfer && !zero_act && word_addr == 2'h1)
      |=> in_q[1] == $past(word_data))
    else $error("Transfer missed addressed register");
  AST_SHIFT_MSB: assert property ( // R09
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    shift_en |=> shift_q[0] == $past(sdi_lvl)
      && shift_q[11:1] == $past(shift_q[10:0]))
    else $error("Shift order wrong");
  AST_PD_OPEN: assert property ( // R12
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    hw_pd_req |=> (drv_q == 4'h0 && hw_pd_q))
    else $error("Outputs driven in powerdown");
  AST_CLEAR_WINS: assert property ( // R21
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    s_clear_held |=> dac_q[0] == 8'h00 && in_q[0] == 8'h00)
    else $error("Clear overridden");
  AST_LOAD_TO_OUT: assert property ( // R16
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    s_load_open ##1 1'b1 |=> out_q[0] == $past(in_q[0], 2))
    else $error("Output missed loaded code");
  AST_PAR_WRITE: assert property ( // R14
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    s_par_write_d |=> in_q[3] == $past(pdat_s))
    else $error("Parallel write missed register");
  AST_PAR_HOLD: assert property ( // R14
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (par_mode && wr_lvl && !zero_act) |=> $stable(in_q[2]))
    else $error("Input register moved without write");
  AST_NO_STRAY_XFER: assert property ( // R06
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (!par_mode && !cs_rise && !zero_act) |=> $stable(in_q[0]))
    else $error("Input register moved without select rise");
  AST_LOAD_ANY_SEL: assert property ( // R07
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    (load_act && !zero_act && !cs_lvl) |=> dac_q[2] == $past(in_q[2]))
    else $error("Select disturbed load");
  AST_SW_PD_OPEN: assert property ( // R12
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    sw_pd_q[0] |=> !drv_q[0])
    else $error("Shut channel still driven");
  AST_PD_KEEPS_CODE: assert property ( // R11
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
    hw_pd_req |=> out_q[1] == $past(dac_q[1]))
    else $error("Powerdown changed output code");
  AST_RESET_ZERO: assert property ( // R20
    @(posedge REF_CLK_IN)
    SRST_IN |=> (dac_q[1] == 8'h00 && in_q[1] == 8'h00))
    else $error("Reset left registers nonzero");
endmodule : qdac_core
`default_nettype wire

// File: test/qdac_host_model.sv
// Host-side serial driver for the converter front end
`timescale 1ns/1ps
`default_nettype none
module qdac_host_model (
  input  wire logic clk_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  output logic      float_out
);
  initial begin
    cs_n_out  = 1'b1;
    sclk_out  = 1'b0;
    sdi_out   = 1'b0;
    float_out = 1'b0;
  end
  // Four reference periods per phase give the 800 ns serial period
  task automatic half;
    repeat (4) @(posedge clk_in);
  endtask : half
  // Sends n bits of w; with sel low chip select stays high while clock and data move
  task automatic send(input logic [15:0] w, input int n, input logic sel);
    @(posedge clk_in);
    cs_n_out <= ~sel;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out <= w[i];
      half();
      sclk_out <= 1'b1;
      half();
      sclk_out <= 1'b0;
    end
    half();
    cs_n_out <= 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    sdi_out  <= ~sdi_out;
  endtask : send
  task automatic release_pin(input logic f);
    @(posedge clk_in);
    float_out <= f;
  endtask : release_pin
endmodule : qdac_host_model
`default_nettype wire

// File: test/qdac_core_tb.sv
// Self-checking bench for the quad converter front end
`timescale 1ns/1ps
`default_nettype none
module qdac_core_tb;
  logic       clk = 1'b0, srst = 1'b1, pmode = 1'b0, ld_n = 1'b1;
  logic       clr_n = 1'b1, wr_n = 1'b1, a_hi = 1'b0, a_lo = 1'b0;
  logic       lo_fl = 1'b0, hwp, hwpd, cs_n, sclk, sdi, sfl;
  logic [7:0] pdata = 8'h00, d, ch_a, ch_b, ch_c, ch_d;
  logic [3:0] den, swp, swpd;
  logic [1:0] pdt[4] = '{2'b10, 2'b11, 2'b01, 2'b11};
  int         failures = 0, n_tests = 0, seed = 58789;
  int         in_m[4], dac_m[4];
  qdac_host_model u_qdac_host_model (.clk_in(clk), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi), .float_out(sfl));
  qdac_core u_qdac_core (.REF_CLK_IN(clk), .SRST_IN(srst),
    .PARALLEL_MODE_IN(pmode), .CHIP_SEL_N_IN(cs_n), .SERIAL_CLK_IN(sclk),
    .SERIAL_IN_OR_POWERDOWN_IN(sdi), .SERIAL_IN_FLOAT_IN(sfl),
    .PAR_DATA_IN(pdata), .WRITE_STROBE_N_IN(wr_n),
    .REG_SELECT_HI_IN(a_hi), .REG_SELECT_LO_OR_POWERDOWN_IN(a_lo),
    .REG_SELECT_LO_FLOAT_IN(lo_fl), .LOAD_OUTPUT_STROBE_N_IN(ld_n),
    .ASYNC_ZERO_N_IN(clr_n), .CHANNEL_A_OUTPUT_OUT(ch_a),
    .CHANNEL_B_OUTPUT_OUT(ch_b), .CHANNEL_C_OUTPUT_OUT(ch_c),
    .CHANNEL_D_OUTPUT_OUT(ch_d), .CHANNEL_DRIVE_EN_OUT(den),
    .HW_POWERDOWN_OUT(hwp), .SW_POWERDOWN_OUT(swp));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic cmp_code(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: code %h expected %h", $time, got, exp);
    end
  endtask : cmp_code
  task automatic cmp_st(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: state %h expected %h", $time, got, exp);
    end
  endtask : cmp_st
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // Model follows the strobe levels after the sync delay has passed
  task automatic settle;
    logic [7:0] got[4];
    if (!clr_n) begin
      in_m  = '{default: 0};
      dac_m = '{default: 0};
    end
    if (!ld_n) dac_m = in_m;
    got = '{ch_a, ch_b, ch_c, ch_d};
    for (int c = 0; c < 4; c++) cmp_code(got[c], 8'(dac_m[c]));
    cmp_st({hwp, swp, den}, {hwpd, swpd, hwpd ? 4'h0 : ~swpd});
  endtask : settle
  task automatic mdl(input logic [11:0] w);
    in_m[w[9:8]] = w[7:0];
    // Each word replaces the earlier shutdown set; all-shut wins over one
    swpd = w[11] ? 4'h0 : 4'hf;
    if (w[11] && !w[10]) swpd[w[9:8]] = 1'b1;
    settle();
  endtask : mdl
  task automatic ser(input logic [15:0] w, input int n);
    u_qdac_host_model.send(w, n, 1'b1);
    wt(10);
    mdl(w[11:0]);
  endtask : ser
  task automatic setld(input logic v);
    @(posedge clk);
    ld_n <= v;
    wt(10);
    settle();
  endtask : setld
  task automatic setclr(input logic v);
    @(posedge clk);
    clr_n <= v;
    wt(10);
    settle();
  endtask : setclr
  task automatic chk_hw(input logic v);
    wt(10);
    hwpd = v;
    settle();
  endtask : chk_hw
  task automatic rst(input int n);
    @(posedge clk);
    srst <= 1'b1;
    wt(n);
    srst <= 1'b0;
    wt(10);
    in_m  = '{default: 0};
    dac_m = '{default: 0};
    swpd  = 4'h0;
    hwpd  = 1'b0;
    settle();
  endtask : rst
  task automatic pwr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    {a_hi, a_lo} <= a;
    pdata <= v;
    wt(3);
    wr_n <= 1'b0;
    wt(5);
    wr_n <= 1'b1;
    wt(3);
    // Data moves after the strobe closes and must not reach the register
    pdata <= ~v;
    wt(10);
    in_m[a] = v;
    settle();
  endtask : pwr
  initial begin
    rst(20);
    $display("test reset done");
    for (int c = 0; c < 4; c++) ser({2'b11, 2'(c), 8'($random(seed))}, 12);
    setld(1'b0);
    ser({4'b1101, 8'($random(seed))}, 12);
    setld(1'b1);
    ser({4'b1101, 8'($random(seed))}, 12);
    setld(1'b0);
    ser({4'h5, 4'b1111, 8'($random(seed))}, 16);
    $display("test serial done");
    d = 8'($random(seed));
    ser({4'b1101, d[7:4], 4'b1110}, 12);
    setclr(1'b0);
    setclr(1'b1);
    u_qdac_host_model.send(16'h00a5, 4, 1'b0);
    d = 8'($random(seed));
    u_qdac_host_model.send({8'h00, d}, 8, 1'b1);
    wt(10);
    mdl({4'b1110, d});
    setclr(1'b0);
    ser({4'b1110, 8'($random(seed))}, 12);
    setclr(1'b1);
    $display("test clear done");
    for (int i = 0; i < 4; i++) ser({pdt[i], 2'(i), 8'($random(seed))}, 12);
    u_qdac_host_model.release_pin(1'b1);
    chk_hw(1'b1);
    u_qdac_host_model.release_pin(1'b0);
    chk_hw(1'b0);
    $display("test powerdown done");
    pmode <= 1'b1;
    rst(3);
    for (int c = 0; c < 4; c++) pwr(2'(c), 8'($random(seed)));
    lo_fl <= 1'b1;
    chk_hw(1'b1);
    lo_fl <= 1'b0;
    chk_hw(1'b0);
    $display("test parallel done");
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : qdac_core_tb
`default_nettype wire
